// File: verilog/tprio_params.svh
// Timing counts, reset values and register addresses for the trip-point and remote input block.
// Assumes a 100 MHz core clock and a register port with read data one cycle after the read strobe.
`ifndef TPRIO_PARAMS_SVH
`define TPRIO_PARAMS_SVH
`define TPRIO_CLK_MHZ 100
`define TPRIO_CLEAR_MS 100
`define TPRIO_ZERO_MS 200
`define TPRIO_SETTLE_US 1000
`define TPRIO_CLEAR_CYC (`TPRIO_CLEAR_MS * 1000 * `TPRIO_CLK_MHZ)
`define TPRIO_ZERO_CYC (`TPRIO_ZERO_MS * 1000 * `TPRIO_CLK_MHZ)
`define TPRIO_SETTLE_CYC (`TPRIO_SETTLE_US * `TPRIO_CLK_MHZ)
// Full scale is 10000 counts, so 105 percent is 10500 counts and 2 percent is 200 counts.
`define TPRIO_FS_PLUS 16'sh2904
`define TPRIO_FS_MINUS -16'sh2904
`define TPRIO_HYST_RST 16'h0064
`define TPRIO_CHAN_RST 2'h1
`define TPRIO_ZERO_LIMIT 16'sh00C8
`define TPRIO_A_CFG0 4'h0
`define TPRIO_A_CFG1 4'h1
`define TPRIO_B_CFG0 4'h2
`define TPRIO_B_CFG1 4'h3
`define TPRIO_CTRL 4'h4
`define TPRIO_STATUS 4'h5
`define TPRIO_IRQ_STAT 4'h6
`define TPRIO_IRQ_MASK 4'h7
`define TPRIO_RANGE_RST 2'h0
`endif

// File: verilog/tprio_pkg.sv
// Types shared by the trip-point and remote input block.
// Assumes the params header supplies every number.
package tprio_pkg;
	// Range selection, x1 down to x0.01.
	typedef enum logic [1:0] {TPRIO_X1, TPRIO_X01, TPRIO_X001} tprio_range_t;
	// One trip point's settings.
	typedef struct packed {
		logic signed [15:0] high;
		logic signed [15:0] low;
		logic [15:0] hyst;
		logic [1:0] chan;
		logic normal_energized;
		logic latch_enable;
	} tprio_tp_cfg_t;
	// Three channel readings, 10000 counts per hundred percent of full scale.
	typedef struct packed {
		logic signed [15:0] ch3;
		logic signed [15:0] ch2;
		logic signed [15:0] ch1;
	} tprio_readings_t;
endpackage

// File: verilog/tprio_core.sv
// Trip-point comparators, relay drive, latch clear, remote range and remote zero logic.
// Assumes readings arrive on core_clk from the converter; pins come from pulled-up open inputs.
`timescale 1ns/1ps
`include "tprio_params.svh"
module tprio_core
	import tprio_pkg::*;
#(
	parameter int CLEAR_CYC = `TPRIO_CLEAR_CYC,
	parameter int ZERO_CYC = `TPRIO_ZERO_CYC,
	parameter int SETTLE_CYC = `TPRIO_SETTLE_CYC
)
(
	input wire logic core_clk, // Core clock, 100 MHz.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic clk_en, // Freezes all state while low.
	input wire logic [3:0] reg_addr, // Register word index.
	input wire logic [31:0] reg_wdata, // Write data.
	input wire logic reg_wr, // Write strobe.
	input wire logic reg_rd, // Read strobe.
	output logic [31:0] reg_rdata, // Read data, one cycle after the strobe.
	input wire tprio_readings_t readings, // Channel readings.
	input wire logic reading_stable, // Converter reports a settled reading.
	input wire logic remote_key, // Key lock in remote position, a pin.
	input wire logic first_latch_clear_in, // Latch clear for the first trip point, low active pin.
	input wire logic second_latch_clear_in, // Latch clear for the second trip point, low active pin.
	input wire logic range_sel1_in, // First range select pin.
	input wire logic range_sel2_in, // Second range select pin.
	input wire logic zero_in, // Remote zero pin, falling edge acts.
	output logic [1:0] relay_out, // Relay coils, one per trip point.
	output tprio_range_t range_q, // Range in force.
	output logic zero_pulse_q, // One-cycle zero command to channel 1.
	output logic irq_q // Interrupt, high while an unmasked status bit is set.
);

////////////////////////////////////////////////////////////////////////////////
// Synchronisers and state.

logic [4:0] pin_s1_q; // First stage, read only by the second.
logic [4:0] pin_s2_q; // Second stage, safe to use.
logic key_s1_q; // Key lock first stage, read only by the second.
logic key_s2_q; // Key lock in remote position, synchronised.
tprio_tp_cfg_t cfg_q [2]; // Settings of each trip point.
logic zero_enable_q; // Zero function enabled.
logic [1:0] tripped_q; // Trip condition present.
logic [1:0] latched_q; // Latched trip held.
logic [31:0] clr_cnt_q [2]; // Low-time counters of latch clear pins.
logic [31:0] zero_cnt_q; // Time the zero pin has held its present level.
logic zero_armed_q; // A new falling edge may act.
logic zero_prev_q; // Zero pin level last cycle.
logic [31:0] settle_cnt_q; // Cycles since the last range change.
logic settling_q; // Trips held off after a range change.
logic zero_refused_q; // Last zero was refused.
logic [3:0] irq_stat_q; // Sticky events: trip A, trip B, zero done, zero refused.
logic [3:0] irq_mask_q; // Enables of the sticky events.
logic [3:0] irq_set; // Events of this cycle.
tprio_range_t range_d; // Next range.
logic range_chg; // Range changes this cycle.
logic zero_req; // Zero request accepted this cycle.

// Pins pass two flops; pulled-up inputs read high when open.
// The key lock is a switch as well, so it is synchronised too and starts in local mode.
always_ff @(posedge core_clk)
begin
	if (sys_rst)
	begin
		pin_s1_q <= 5'h1F;
		pin_s2_q <= 5'h1F;
		key_s1_q <= 1'b0;
		key_s2_q <= 1'b0;
	end
	else if (clk_en)
	begin
		pin_s1_q <= {zero_in, range_sel2_in, range_sel1_in, second_latch_clear_in, first_latch_clear_in};
		pin_s2_q <= pin_s1_q;
		key_s1_q <= remote_key;
		key_s2_q <= key_s1_q;
	end
end

// Picks a channel reading; channels 2 and 3 work with or without a multiplexer.
function automatic logic signed [15:0] pick(input tprio_readings_t r, input logic [1:0] ch);
	case (ch)
		2'h2: pick = r.ch2;
		2'h3: pick = r.ch3;
		default: pick = r.ch1;
	endcase
endfunction

// True when a reading lies beyond the zero limit either way; such a transducer is not zeroed.
function automatic logic beyond_limit(input logic signed [15:0] v);
	beyond_limit = (v > `TPRIO_ZERO_LIMIT) || (v < -`TPRIO_ZERO_LIMIT);
endfunction

////////////////////////////////////////////////////////////////////////////////
// Register port.

// Software writes settings; the write-one-to-clear status lets a new event win.
always_ff @(posedge core_clk)
begin
	if (sys_rst)
	begin
		for (int i = 0; i < 2; i++)
		begin
			cfg_q[i] <= '{high: `TPRIO_FS_PLUS, low: `TPRIO_FS_MINUS, hyst: `TPRIO_HYST_RST, chan: `TPRIO_CHAN_RST,
				normal_energized: 1'b1, latch_enable: 1'b0};
		end
		zero_enable_q <= 1'b0;
		irq_mask_q <= 4'h0;
		irq_stat_q <= 4'h0;
	end
	else if (clk_en)
	begin
		irq_stat_q <= (irq_stat_q & ~((reg_wr && reg_addr == `TPRIO_IRQ_STAT) ? reg_wdata[3:0] : 4'h0)) | irq_set;
		if (reg_wr)
		begin
			case (reg_addr)
				// The high threshold is clamped only at the top of the entry span, the low one only at the bottom.
				`TPRIO_A_CFG0, `TPRIO_B_CFG0:
				begin
					cfg_q[reg_addr[1]].high <= ($signed(reg_wdata[31:16]) > `TPRIO_FS_PLUS) ? `TPRIO_FS_PLUS
						: reg_wdata[31:16];
					cfg_q[reg_addr[1]].low <= ($signed(reg_wdata[15:0]) < `TPRIO_FS_MINUS) ? `TPRIO_FS_MINUS
						: reg_wdata[15:0];
				end
				`TPRIO_A_CFG1, `TPRIO_B_CFG1:
				begin
					cfg_q[reg_addr[1]].hyst <= reg_wdata[15:0];
					cfg_q[reg_addr[1]].chan <= (reg_wdata[17:16] == 2'h0) ? 2'h1 : reg_wdata[17:16];
					cfg_q[reg_addr[1]].normal_energized <= reg_wdata[18];
					cfg_q[reg_addr[1]].latch_enable <= reg_wdata[19];
				end
				`TPRIO_CTRL: zero_enable_q <= reg_wdata[0];
				`TPRIO_IRQ_MASK: irq_mask_q <= reg_wdata[3:0];
				default: ;
			endcase
		end
	end
end

// Read data one cycle after the strobe, zero elsewhere and on unmapped words.
always_ff @(posedge core_clk)
begin
	if (sys_rst)
		reg_rdata <= 32'h0;
	else if (clk_en)
	begin
		reg_rdata <= 32'h0;
		if (reg_rd)
		begin
			case (reg_addr)
				`TPRIO_A_CFG0, `TPRIO_B_CFG0: reg_rdata <= {cfg_q[reg_addr[1]].high, cfg_q[reg_addr[1]].low};
				`TPRIO_A_CFG1, `TPRIO_B_CFG1: reg_rdata <= {12'h0, cfg_q[reg_addr[1]].latch_enable,
					cfg_q[reg_addr[1]].normal_energized, cfg_q[reg_addr[1]].chan, cfg_q[reg_addr[1]].hyst};
				`TPRIO_CTRL: reg_rdata <= {31'h0, zero_enable_q};
				`TPRIO_STATUS: reg_rdata <= {24'h0, zero_refused_q, settling_q, range_q, latched_q, tripped_q};
				`TPRIO_IRQ_STAT: reg_rdata <= {28'h0, irq_stat_q};
				`TPRIO_IRQ_MASK: reg_rdata <= {28'h0, irq_mask_q};
				default: reg_rdata <= 32'h0;
			endcase
		end
	end
end

// The interrupt line is a flop of the masked status.
always_ff @(posedge core_clk)
begin
	if (sys_rst)
		irq_q <= 1'b0;
	else if (clk_en)
		irq_q <= |(irq_stat_q & irq_mask_q);
end

////////////////////////////////////////////////////////////////////////////////
// Remote range selection.

// Decode only in remote mode; both low is undefined and holds the range.
// Local mode leaves the present range in place, so turning the key to local never moves it.
always_comb
begin
	range_d = range_q;
	if (key_s2_q)
	begin
		case ({pin_s2_q[2], pin_s2_q[3]})
			2'b11: range_d = TPRIO_X1;
			2'b01: range_d = TPRIO_X01;
			2'b10: range_d = TPRIO_X001;
			default: range_d = range_q;
		endcase
	end
end
assign range_chg = (range_d != range_q);

// Range register and the settle hold-off after each change.
always_ff @(posedge core_clk)
begin
	if (sys_rst)
	begin
		range_q <= tprio_range_t'(`TPRIO_RANGE_RST);
		settling_q <= 1'b0;
		settle_cnt_q <= 32'h0;
	end
	else if (clk_en)
	begin
		range_q <= range_d;
		if (range_chg)
		begin
			settling_q <= 1'b1;
			settle_cnt_q <= 32'h0;
		end
		else if (settling_q)
		begin
			// Held off for a minimum time, then until the converter calls the reading stable.
			if (settle_cnt_q < 32'(SETTLE_CYC))
				settle_cnt_q <= settle_cnt_q + 32'h1;
			else if (reading_stable)
				settling_q <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Trip points.

// Each trip point compares and latches on its own; trips frozen while settling.
always_ff @(posedge core_clk)
begin
	if (sys_rst)
	begin
		tripped_q <= 2'b00;
		latched_q <= 2'b00;
		relay_out <= 2'b00;
		clr_cnt_q[0] <= 32'h0;
		clr_cnt_q[1] <= 32'h0;
	end
	else if (clk_en)
	begin
		for (int i = 0; i < 2; i++)
		begin
			logic signed [16:0] rd;
			logic hi_on;
			logic lo_on;
			logic hi_off;
			logic lo_off;
			logic clear;
			rd = 17'(pick(readings, cfg_q[i].chan));
			hi_on = (cfg_q[i].high != `TPRIO_FS_PLUS) && (rd > 17'(cfg_q[i].high));
			lo_on = (cfg_q[i].low != `TPRIO_FS_MINUS) && (rd < 17'(cfg_q[i].low));
			hi_off = rd <= 17'(cfg_q[i].high) - $signed({1'b0, cfg_q[i].hyst});
			lo_off = rd >= 17'(cfg_q[i].low) + $signed({1'b0, cfg_q[i].hyst});
			// Clear needs the pin low long enough and remote mode.
			if (!pin_s2_q[i] && key_s2_q)
				clr_cnt_q[i] <= (clr_cnt_q[i] < 32'(CLEAR_CYC)) ? clr_cnt_q[i] + 32'h1 : clr_cnt_q[i];
			else
				clr_cnt_q[i] <= 32'h0;
			clear = (clr_cnt_q[i] >= 32'(CLEAR_CYC));
			if (!settling_q)
			begin
				if (hi_on || lo_on)
					tripped_q[i] <= 1'b1;
				else if (hi_off && lo_off)
					tripped_q[i] <= 1'b0;
			end
			// A new trip wins over the clear, and the enable stays set.
			if (cfg_q[i].latch_enable && tripped_q[i])
				latched_q[i] <= 1'b1;
			else if (clear || !cfg_q[i].latch_enable)
				latched_q[i] <= 1'b0;
			// The relay sits in its normal state until tripped.
			relay_out[i] <= cfg_q[i].normal_energized ^ (tripped_q[i] | latched_q[i]);
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Remote zero.

assign zero_req = zero_prev_q && !pin_s2_q[4] && zero_armed_q && zero_enable_q && key_s2_q;

// One zero per falling edge; re-armed only after a long enough release.
always_ff @(posedge core_clk)
begin
	if (sys_rst)
	begin
		zero_prev_q <= 1'b1;
		zero_armed_q <= 1'b1;
		zero_cnt_q <= 32'h0;
		zero_pulse_q <= 1'b0;
		zero_refused_q <= 1'b0;
	end
	else if (clk_en)
	begin
		zero_prev_q <= pin_s2_q[4];
		zero_pulse_q <= 1'b0;
		if (zero_prev_q != pin_s2_q[4])
			zero_cnt_q <= 32'h0;
		else if (zero_cnt_q < 32'(ZERO_CYC))
			zero_cnt_q <= zero_cnt_q + 32'h1;
		if (zero_req)
			zero_armed_q <= 1'b0;
		else if (pin_s2_q[4] && zero_cnt_q >= 32'(ZERO_CYC))
			zero_armed_q <= 1'b1;
		if (zero_req)
		begin
			// Refused when channel 1 reads beyond 2 percent.
			zero_refused_q <= beyond_limit(readings.ch1);
			zero_pulse_q <= !beyond_limit(readings.ch1);
		end
	end
end

// Events: a refused zero, a finished zero, and each trip point that is tripped but not latched.
assign irq_set = {zero_req && beyond_limit(readings.ch1), zero_pulse_q, tripped_q[1] & ~latched_q[1],
	tripped_q[0] & ~latched_q[0]};

////////////////////////////////////////////////////////////////////////////////
// Checks.

zero_once_a: assert property (@(posedge core_clk) disable iff (sys_rst)
	(clk_en && zero_pulse_q) |=> !zero_pulse_q) else $error("zero pulse repeated");
zero_local_a: assert property (@(posedge core_clk) disable iff (sys_rst)
	(clk_en && !key_s2_q) |=> !zero_pulse_q) else $error("zero taken in local mode");
range_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
	(clk_en && key_s2_q && !pin_s2_q[2] && !pin_s2_q[3]) |=> $stable(range_q)) else $error("range moved");
range_local_a: assert property (@(posedge core_clk) disable iff (sys_rst)
	(clk_en && !key_s2_q) |=> $stable(range_q)) else $error("range moved in local mode");
settle_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
	(clk_en && settling_q) |=> $stable(tripped_q)) else $error("trip changed while settling");
high_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
	(clk_en && cfg_q[0].high == `TPRIO_FS_PLUS && cfg_q[0].low == `TPRIO_FS_MINUS && !tripped_q[0])
	|=> !tripped_q[0]) else $error("disabled trip point tripped");
low_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
	(clk_en && cfg_q[0].low == `TPRIO_FS_MINUS && !tripped_q[0] && pick(readings, cfg_q[0].chan) <= cfg_q[0].high)
	|=> !tripped_q[0]) else $error("disabled low comparison tripped");
latch_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
	(clk_en && latched_q[0] && cfg_q[0].latch_enable && clr_cnt_q[0] < 32'(CLEAR_CYC)) |=> latched_q[0])
	else $error("latch dropped without clear");
clear_local_a: assert property (@(posedge core_clk) disable iff (sys_rst)
	(clk_en && !key_s2_q) |=> (clr_cnt_q[0] == 32'h0 && clr_cnt_q[1] == 32'h0))
	else $error("latch clear counted in local mode");
relay_norm_a: assert property (@(posedge core_clk) disable iff (sys_rst)
	(clk_en && !tripped_q[1] && !latched_q[1]) |=> relay_out[1] == $past(cfg_q[1].normal_energized))
	else $error("relay left normal state");
relay_trip_a: assert property (@(posedge core_clk) disable iff (sys_rst)
	(clk_en && tripped_q[0]) |=> relay_out[0] != $past(cfg_q[0].normal_energized))
	else $error("relay stayed normal while tripped");
zero_refuse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
	(clk_en && zero_req && (readings.ch1 > `TPRIO_ZERO_LIMIT || readings.ch1 < -`TPRIO_ZERO_LIMIT))
	|=> !zero_pulse_q) else $error("zero beyond limit");
endmodule

// File: tb/tprio_wiring.sv
// Model of the user's system wiring on the control pins of the trip-point block.
// Assumes the bench raises a short bit to ground a pin and lowers it to let the pin go open.
`timescale 1ns/1ps
module tprio_wiring
(
	input wire logic [4:0] short_q, // Grounded pins: latch A, latch B, range 1, range 2, zero.
	output logic [4:0] pin // Pin levels that the block sees.
);
	////////////////////////////////////////////////////////////////////////////////
	// Every pin has a pull-up, so a released pin reads high and is never driven high.
	// Hold times for a latch clear or a zero request are left to whoever grounds the pin.
	assign pin = ~short_q;
endmodule

// File: tb/tprio_test.sv
// Self-checking bench for the trip-point and remote input block.
// Assumes the wiring model feeds the pins and short counts replace the long hold times.
`timescale 1ns/1ps
module tprio_test
	import tprio_pkg::*;
;
	logic core_clk = 1'b0; // Core clock, 100 MHz.
	logic sys_rst = 1'b1; // Synchronous reset.
	logic [3:0] reg_addr = 4'h0; // Register index.
	logic [31:0] reg_wdata = 32'h0; // Write data.
	logic reg_wr = 1'b0; // Write strobe.
	logic reg_rd = 1'b0; // Read strobe.
	logic [31:0] reg_rdata; // Read data.
	tprio_readings_t readings = '0; // Channel readings.
	logic reading_stable = 1'b1; // Converter settled.
	logic remote_key = 1'b1; // Key lock in remote.
	logic [4:0] short_q = 5'h00; // Pins grounded by the wiring.
	logic [4:0] pin; // Pin levels.
	logic [1:0] relay_out; // Relay coils.
	tprio_range_t range_q; // Range in force.
	logic zero_pulse_q; // Zero command.
	logic irq_q; // Interrupt.
	int error_cnt = 0; // Mismatches.
	int n_tests = 0; // Comparisons.
	int cyc = 0; // Cycles run, for the hang guard.
	int cnt; // Zero pulses seen.
	logic [31:0] rd; // Last read data.
	logic [4:0] rs [4] = '{5'h04, 5'h08, 5'h0C, 5'h00}; // Range pin patterns.
	logic [1:0] rx [4] = '{2'h1, 2'h2, 2'h2, 2'h0}; // Ranges they should give.

	tprio_wiring wiring_u (.short_q(short_q), .pin(pin));
	// Short counts keep the run brief; every expectation below is built on 8, 8 and 4.
	tprio_core #(.CLEAR_CYC(8), .ZERO_CYC(8), .SETTLE_CYC(4)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
		.clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .readings(readings), .reading_stable(reading_stable), .remote_key(remote_key),
		.first_latch_clear_in(pin[0]), .second_latch_clear_in(pin[1]), .range_sel1_in(pin[2]),
		.range_sel2_in(pin[3]), .zero_in(pin[4]), .relay_out(relay_out), .range_q(range_q),
		.zero_pulse_q(zero_pulse_q), .irq_q(irq_q));

	////////////////////////////////////////////////////////////////////////////////
	// Free-running clock and a guard that cuts a hang short.
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Prints the verdict and ends the run.
	task automatic conclude();
		if (error_cnt == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Compares one value and reports a difference at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Register write: one cycle with the strobe high.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// Register read: data stands only in the cycle after the strobe.
	task automatic rdr(input logic [3:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		rd = reg_rdata;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// Applies readings and gives them time to reach the relays.
	task automatic feed(input logic [15:0] c1, input logic [15:0] c2, input logic [15:0] c3);
		@(posedge core_clk);
		readings <= {c3, c2, c1};
		step(6);
	endtask
	// Grounds pins for n+1 cycles, then leaves them open 15 cycles, counting zero pulses.
	task automatic ground(input logic [4:0] s, input int n);
		cnt = 0;
		@(posedge core_clk);
		short_q <= s;
		for (int i = 0; i < n + 16; i++)
		begin
			@(posedge core_clk);
			if (zero_pulse_q === 1'b1)
				cnt++;
			if (i == n)
				short_q <= 5'h00;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset, trips, latch, range, zero.
	initial
	begin
		step(20);
		sys_rst <= 1'b0;
		step(3);
		chk({30'h0, relay_out}, 32'h3);
		chk({30'h0, range_q}, 32'h0);
		rdr(4'h1);
		chk(rd, 32'h0005_0064);
		rdr(4'h8);
		chk(rd, 32'h0);
		// Only the first trip point's event may raise the interrupt for now.
		wr(4'h7, 32'h1);
		wr(4'h6, 32'hF);
		wr(4'h0, 32'h03E8_FC18);
		wr(4'h2, 32'h07D0_F830);
		wr(4'h3, 32'h0002_00C8);
		step(4);
		chk({30'h0, relay_out}, 32'h1);
		chk({31'h0, irq_q}, 32'h0);
		// Channel three is over the second threshold but that trip point watches channel two.
		feed(16'h03E9, 16'h0000, 16'h07D1);
		chk({30'h0, relay_out}, 32'h0);
		chk({31'h0, irq_q}, 32'h1);
		wr(4'h7, 32'h0);
		step(2);
		chk({31'h0, irq_q}, 32'h0);
		feed(16'h03B6, 16'h0000, 16'h0000);
		chk({30'h0, relay_out}, 32'h0);
		feed(16'h0352, 16'h0000, 16'h0000);
		chk({30'h0, relay_out}, 32'h1);
		wr(4'h6, 32'hF);
		wr(4'h7, 32'hE);
		step(2);
		chk({31'h0, irq_q}, 32'h0);
		feed(16'hFC17, 16'h0000, 16'h0000);
		chk({30'h0, relay_out}, 32'h0);
		feed(16'hFCAE, 16'h07D1, 16'h0000);
		chk({30'h0, relay_out}, 32'h3);
		feed(16'h0000, 16'h073A, 16'h0000);
		chk({30'h0, relay_out}, 32'h3);
		feed(16'h0000, 16'h06A4, 16'h0000);
		chk({30'h0, relay_out}, 32'h1);
		wr(4'h3, 32'h0003_00C8);
		feed(16'h0000, 16'h0000, 16'h07D1);
		chk({30'h0, relay_out}, 32'h3);
		feed(16'h0000, 16'h0000, 16'h0000);
		// Out-of-range thresholds clamp to the disabling values.
		wr(4'h0, 32'h3000_D000);
		rdr(4'h0);
		chk(rd, 32'h2904_D6FC);
		feed(16'h2AF8, 16'h0000, 16'h0000);
		chk({30'h0, relay_out}, 32'h1);
		feed(16'hD508, 16'h0000, 16'h0000);
		chk({30'h0, relay_out}, 32'h1);
		wr(4'h0, 32'h03E8_FC18);
		wr(4'h1, 32'h000C_0064);
		feed(16'h05DC, 16'h0000, 16'h0000);
		feed(16'h0000, 16'h0000, 16'h0000);
		chk({30'h0, relay_out}, 32'h0);
		remote_key <= 1'b0;
		ground(5'h03, 14);
		chk({30'h0, relay_out}, 32'h0);
		remote_key <= 1'b1;
		ground(5'h03, 14);
		chk({30'h0, relay_out}, 32'h1);
		feed(16'h05DC, 16'h0000, 16'h0000);
		feed(16'h0000, 16'h0000, 16'h0000);
		chk({30'h0, relay_out}, 32'h0);
		ground(5'h01, 14);
		chk({30'h0, relay_out}, 32'h1);
		wr(4'h1, 32'h0004_0064);
		// Range pins are ignored in local mode, then decoded in remote mode.
		remote_key <= 1'b0;
		short_q <= 5'h04;
		step(10);
		chk({30'h0, range_q}, 32'h0);
		remote_key <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			short_q <= rs[i];
			step(10);
			rdr(4'h5);
			chk({30'h0, range_q}, {30'h0, rx[i]});
			chk((rd >> 4) & 32'h3, {30'h0, rx[i]});
		end
		// A range change holds off trips until the reading is stable.
		// The range change must be in force before the reading rises.
		reading_stable <= 1'b0;
		short_q <= 5'h04;
		step(4);
		feed(16'h05DC, 16'h0000, 16'h0000);
		step(14);
		chk({30'h0, relay_out}, 32'h1);
		rdr(4'h5);
		chk(rd & 32'h40, 32'h40);
		reading_stable <= 1'b1;
		feed(16'h05DC, 16'h0000, 16'h0000);
		chk({30'h0, relay_out}, 32'h0);
		short_q <= 5'h00;
		feed(16'h0064, 16'h0000, 16'h0000);
		step(10);
		wr(4'h4, 32'h1);
		ground(5'h10, 14);
		chk(cnt, 32'h1);
		ground(5'h10, 14);
		chk(cnt, 32'h1);
		feed(16'h012C, 16'h0000, 16'h0000);
		ground(5'h10, 14);
		chk(cnt, 32'h0);
		rdr(4'h5);
		chk(rd & 32'h80, 32'h80);
		feed(16'h0064, 16'h0000, 16'h0000);
		wr(4'h4, 32'h0);
		ground(5'h10, 14);
		chk(cnt, 32'h0);
		wr(4'h4, 32'h1);
		remote_key <= 1'b0;
		ground(5'h10, 14);
		chk(cnt, 32'h0);
		conclude();
	end
endmodule
